// >>> pvwd_pkg.sv
package pvwd_pkg;
  localparam int unsigned PVWD_NUM_IMG = 3;
  localparam int unsigned PVWD_AW = 12;
  // register offsets (byte addresses)
  localparam logic [11:0] PVWD_IMG5_CTL_OFS = 12'h1B4;
  localparam logic [11:0] PVWD_IMG5_BS_OFS = 12'h1B8;
  localparam logic [11:0] PVWD_IMG5_BD_OFS = 12'h1BC;
  localparam logic [11:0] PVWD_IMG5_TO_OFS = 12'h1C0;
  localparam logic [11:0] PVWD_IMG6_CTL_OFS = 12'h1C8;
  localparam logic [11:0] PVWD_IMG6_BS_OFS = 12'h1CC;
  localparam logic [11:0] PVWD_IMG6_BD_OFS = 12'h1D0;
  localparam logic [11:0] PVWD_IMG6_TO_OFS = 12'h1D4;
  localparam logic [11:0] PVWD_IMG7_CTL_OFS = 12'h1DC;
  localparam logic [11:0] PVWD_IMG7_BS_OFS = 12'h1E0;
  localparam logic [11:0] PVWD_IMG7_BD_OFS = 12'h1E4;
  localparam logic [11:0] PVWD_IMG7_TO_OFS = 12'h1E8;
  localparam logic [11:0] PVWD_STATUS_OFS = 12'h1F0;
  // control field positions
  localparam int unsigned PVWD_EN_BIT = 31;
  localparam int unsigned PVWD_PW_BIT = 30;
  localparam int unsigned PVWD_VDW_LSB = 22;
  localparam int unsigned PVWD_VAS_LSB = 16;
  localparam int unsigned PVWD_PGM_BIT = 14;
  localparam int unsigned PVWD_SUP_BIT = 12;
  localparam int unsigned PVWD_VCT_BIT = 8;
  localparam int unsigned PVWD_LAS_BIT = 0;
  localparam int unsigned PVWD_WIN_LSB = 16;
  // writable bits of control and window registers
  localparam logic [31:0] PVWD_CTL_MASK = 32'hC0C75101;
  localparam logic [31:0] PVWD_WIN_MASK = 32'hFFFF0000;
  // reset values
  localparam logic [31:0] PVWD_CTL_RST = 32'h00800000;
  localparam logic [31:0] PVWD_WIN_RST = 32'h00000000;
  localparam logic [31:0] PVWD_UNMAPPED_RD = 32'h00000000;
  // data width codes
  typedef enum logic [1:0] {
    PVWD_DW8 = 2'h0, PVWD_DW16 = 2'h1, PVWD_DW32 = 2'h2, PVWD_DW64 = 2'h3
  } pvwd_width_t;
  // space codes
  typedef enum logic [2:0] {
    PVWD_A16 = 3'h0, PVWD_A24 = 3'h1, PVWD_A32 = 3'h2, PVWD_RSV3 = 3'h3,
    PVWD_RSV4 = 3'h4, PVWD_CRCSR = 3'h5, PVWD_USER1 = 3'h6, PVWD_USER2 = 3'h7
  } pvwd_space_t;
endpackage : pvwd_pkg

// >>> pvwd_img_if.sv
`timescale 1ns/1ps
interface pvwd_img_if;
  import pvwd_pkg::*;
  logic [31:0] ctl;
  logic [31:0] base;
  logic [31:0] bound;
  logic [31:0] offs;
  logic [31:0] addr;
  logic io_cycle;
  logic hit;
  logic [15:0] vme_hi;
  modport cfg (output ctl, output base, output bound, output offs, output addr, output io_cycle,
    input hit, input vme_hi);
  modport dec (input ctl, input base, input bound, input offs, input addr, input io_cycle,
    output hit, output vme_hi);
endinterface : pvwd_img_if

// >>> pvwd_img_decode.sv
`timescale 1ns/1ps
module pvwd_img_decode import pvwd_pkg::*; (
  pvwd_img_if.dec img
);
  logic [15:0] a_hi;
  logic above_base;
  logic below_bound;
  logic bound_open;
  assign a_hi = img.addr[31:PVWD_WIN_LSB];
  assign above_base = a_hi >= img.base[31:PVWD_WIN_LSB];
  assign bound_open = img.bound[31:PVWD_WIN_LSB] == 16'h0000;
  assign below_bound = bound_open || (a_hi < img.bound[31:PVWD_WIN_LSB]);
  // enable and space select gate the match
  assign img.hit = img.ctl[PVWD_EN_BIT] && above_base && below_bound
    && (img.ctl[PVWD_LAS_BIT] == img.io_cycle);
  assign img.vme_hi = a_hi + img.offs[31:PVWD_WIN_LSB];
endmodule : pvwd_img_decode

// >>> pvwd_top.sv
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
// What this block does
// - Claim an access only when base <= address < bound, or base <= address with a zero bound.
// - A bound of zero opens the window upward from base.
// - Images 5, 6, 7 compare only address bits 31 to 16.
// - Upper VME address is PCI upper bits plus offset; low bits pass.
// - Enable bit gates decoding; cleared at reset.
// - Posting bit lets writes post; cleared means coupled writes.
// - I/O-space images ignore posting and always run coupled.
// - Two-bit width field selects 8/16/32/64; resets to 32-bit.
// - Three-bit space field selects A16/A24/A32/CR-CSR/User1/User2; resets zero.
// - Program/data bit picks program or data address modifier.
// - Privilege bit picks supervisor or non-privileged modifier.
// - Block transfers honoured only for A24/A32 with width 8/16/32.
// - A24/A32 at 64-bit width may use MBLT regardless of select.
// - Space select: 0 answers memory cycles, 1 answers I/O cycles.
module pvwd_top import pvwd_pkg::*; (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // register port
  input wire logic [PVWD_AW-1:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  // pci request
  input wire logic i_req_valid,
  input wire logic [31:0] i_req_addr,
  input wire logic i_req_io,
  input wire logic i_req_write,
  // decoded vme cycle
  output logic o_claim,
  output logic [1:0] o_img_sel,
  output logic [31:0] o_vme_addr,
  output logic [1:0] o_vme_width,
  output logic [2:0] o_vme_space,
  output logic o_program,
  output logic o_supervisor,
  output logic o_blt,
  output logic o_mblt,
  output logic o_posted,
  output logic o_write
);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [31:0] ctl_q [PVWD_NUM_IMG];
  logic [31:0] base_q [PVWD_NUM_IMG];
  logic [31:0] bound_q [PVWD_NUM_IMG];
  logic [31:0] offs_q [PVWD_NUM_IMG];
  logic [PVWD_NUM_IMG-1:0] hit;
  logic [15:0] vme_hi [PVWD_NUM_IMG];
  logic [31:0] rdata_d;

  // offsets per image
  function automatic logic [11:0] ofs_ctl(input int unsigned i);
    logic [11:0] r;
    case (i)
      0: r = PVWD_IMG5_CTL_OFS;
      1: r = PVWD_IMG6_CTL_OFS;
      default: r = PVWD_IMG7_CTL_OFS;
    endcase
    return r;
  endfunction : ofs_ctl

  function automatic logic [11:0] ofs_bs(input int unsigned i);
    logic [11:0] r;
    case (i)
      0: r = PVWD_IMG5_BS_OFS;
      1: r = PVWD_IMG6_BS_OFS;
      default: r = PVWD_IMG7_BS_OFS;
    endcase
    return r;
  endfunction : ofs_bs

  function automatic logic [11:0] ofs_bd(input int unsigned i);
    logic [11:0] r;
    case (i)
      0: r = PVWD_IMG5_BD_OFS;
      1: r = PVWD_IMG6_BD_OFS;
      default: r = PVWD_IMG7_BD_OFS;
    endcase
    return r;
  endfunction : ofs_bd

  function automatic logic [11:0] ofs_to(input int unsigned i);
    logic [11:0] r;
    case (i)
      0: r = PVWD_IMG5_TO_OFS;
      1: r = PVWD_IMG6_TO_OFS;
      default: r = PVWD_IMG7_TO_OFS;
    endcase
    return r;
  endfunction : ofs_to

  ////////////////////////////////////////////////////////////////////////////
  // per-image registers and decoders
  for (genvar g = 0; g < PVWD_NUM_IMG; g++) begin : g_img
    pvwd_img_if img_if ();

    always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
        ctl_q[g] <= PVWD_CTL_RST;
      end else if (i_reg_wr && i_reg_addr == ofs_ctl(g)) begin
        ctl_q[g] <= i_reg_wdata & PVWD_CTL_MASK;
      end
    end

    always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
        base_q[g] <= PVWD_WIN_RST;
        bound_q[g] <= PVWD_WIN_RST;
        offs_q[g] <= PVWD_WIN_RST;
      end else if (i_reg_wr) begin
        if (i_reg_addr == ofs_bs(g)) begin
          base_q[g] <= i_reg_wdata & PVWD_WIN_MASK;
        end
        if (i_reg_addr == ofs_bd(g)) begin
          bound_q[g] <= i_reg_wdata & PVWD_WIN_MASK;
        end
        if (i_reg_addr == ofs_to(g)) begin
          offs_q[g] <= i_reg_wdata & PVWD_WIN_MASK;
        end
      end
    end

    assign img_if.ctl = ctl_q[g];
    assign img_if.base = base_q[g];
    assign img_if.bound = bound_q[g];
    assign img_if.offs = offs_q[g];
    assign img_if.addr = i_req_addr;
    assign img_if.io_cycle = i_req_io;
    assign hit[g] = img_if.hit;
    assign vme_hi[g] = img_if.vme_hi;

    pvwd_img_decode u_dec (
      .img (img_if.dec)
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read
  always_comb begin
    rdata_d = PVWD_UNMAPPED_RD;
    for (int unsigned i = 0; i < PVWD_NUM_IMG; i++) begin
      if (i_reg_addr == ofs_ctl(i)) begin
        rdata_d = ctl_q[i];
      end
      if (i_reg_addr == ofs_bs(i)) begin
        rdata_d = base_q[i];
      end
      if (i_reg_addr == ofs_bd(i)) begin
        rdata_d = bound_q[i];
      end
      if (i_reg_addr == ofs_to(i)) begin
        rdata_d = offs_q[i];
      end
    end
    if (i_reg_addr == PVWD_STATUS_OFS) begin
      rdata_d = {29'h00000000, hit};
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_reg_rdata <= 32'h00000000;
    end else if (i_reg_rd) begin
      o_reg_rdata <= rdata_d;
    end else begin
      o_reg_rdata <= 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // image selection, lowest image wins
  logic sel_hit;
  logic [1:0] sel_idx;
  logic [31:0] sel_ctl;
  logic [15:0] sel_hi;
  always_comb begin
    sel_hit = 1'b0;
    sel_idx = 2'h0;
    sel_ctl = PVWD_CTL_RST;
    sel_hi = 16'h0000;
    for (int i = PVWD_NUM_IMG - 1; i >= 0; i--) begin
      if (i_req_valid && hit[i]) begin
        sel_hit = 1'b1;
        sel_idx = 2'(i);
        sel_ctl = ctl_q[i];
        sel_hi = vme_hi[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // attributes of the selected image
  logic [1:0] s_width;
  logic [2:0] s_space;
  logic s_long;
  assign s_width = sel_ctl[PVWD_VDW_LSB +: 2];
  assign s_space = sel_ctl[PVWD_VAS_LSB +: 3];
  assign s_long = (s_space == PVWD_A24) || (s_space == PVWD_A32);

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_claim <= 1'b0;
      o_img_sel <= 2'h0;
      o_vme_addr <= 32'h00000000;
      o_write <= 1'b0;
    end else begin
      o_claim <= i_req_valid && sel_hit;
      o_img_sel <= sel_idx;
      o_vme_addr <= {sel_hi, i_req_addr[PVWD_WIN_LSB-1:0]};
      o_write <= i_req_valid && sel_hit && i_req_write;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_vme_width <= PVWD_DW32;
      o_vme_space <= PVWD_A16;
      o_program <= 1'b0;
      o_supervisor <= 1'b0;
    end else begin
      o_vme_width <= s_width;
      o_vme_space <= s_space;
      o_program <= sel_ctl[PVWD_PGM_BIT];
      o_supervisor <= sel_ctl[PVWD_SUP_BIT];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_blt <= 1'b0;
      o_mblt <= 1'b0;
      o_posted <= 1'b0;
    end else begin
      o_blt <= sel_ctl[PVWD_VCT_BIT] && s_long && (s_width != PVWD_DW64);
      o_mblt <= s_long && (s_width == PVWD_DW64);
      o_posted <= i_req_write && sel_ctl[PVWD_PW_BIT] && !sel_ctl[PVWD_LAS_BIT];
    end
  end

endmodule : pvwd_top

// >>> pvwd_monitor.sv
`timescale 1ns/1ps
module pvwd_monitor import pvwd_pkg::*; (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // request
  input wire logic i_req_valid,
  input wire logic [31:0] i_req_addr,
  input wire logic i_req_io,
  input wire logic i_req_write,
  // decode
  input wire logic o_claim,
  input wire logic [1:0] o_img_sel,
  input wire logic [31:0] o_vme_addr,
  input wire logic [1:0] o_vme_width,
  input wire logic [2:0] o_vme_space,
  input wire logic o_blt,
  input wire logic o_mblt,
  input wire logic o_posted,
  input wire logic o_write
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_io_req;
    i_req_valid && i_req_io;
  endsequence
  sequence s_idle;
    !i_req_valid;
  endsequence
  AST_IO_COUPLED: assert property (s_io_req |=> !o_posted) else $error("posted after io");
  AST_NO_REQ: assert property (s_idle |=> !o_claim) else $error("claim without request");
  AST_LOW_PASS: assert property (o_claim |-> o_vme_addr[15:0] == $past(i_req_addr[15:0]))
    else $error("low address bits changed");
  AST_BLT: assert property (o_blt |-> o_vme_space inside {3'h1, 3'h2} && o_vme_width != 2'h3)
    else $error("blt in wrong mode");
  AST_MBLT: assert property (o_mblt == (o_vme_space inside {3'h1, 3'h2} && o_vme_width == 2'h3))
    else $error("mblt mismatch");
  AST_POST_WR: assert property (o_posted |-> o_write && $past(i_req_write)) else $error("posted non-write");
  AST_SEL: assert property (o_claim |-> o_img_sel != 2'h3) else $error("bad image select");
  AST_IDLE_ATTR: assert property (!o_claim |-> o_vme_width == 2'h2 && !o_blt && !o_posted)
    else $error("attributes without claim");
endmodule : pvwd_monitor
bind pvwd_top pvwd_monitor i_pvwd_monitor (.*);

// >>> pvwd_pci_master.sv
`timescale 1ns/1ps
module pvwd_pci_master (
  // clock and command
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic [31:0] i_addr,
  input wire logic [1:0] i_flags,
  // pci request
  output logic o_req_valid,
  output logic [31:0] o_req_addr,
  output logic o_req_io,
  output logic o_req_write
);
  initial {o_req_valid, o_req_addr, o_req_io, o_req_write} = '0;
  // address, io and write lines toggle while no request is present
  always @(posedge i_clk) begin
    o_req_valid <= i_go;
    o_req_addr <= i_go ? i_addr : ~o_req_addr;
    o_req_io <= i_go ? i_flags[0] : ~o_req_io;
    o_req_write <= i_go ? i_flags[1] : ~o_req_write;
  end
endmodule : pvwd_pci_master

// >>> testbench.sv
`timescale 1ns/1ps
module testbench;
  import pvwd_pkg::*;
  logic i_clk = 0, i_rst_n = 0, i_reg_wr = 0, i_reg_rd = 0, go = 0;
  logic [PVWD_AW-1:0] i_reg_addr = '0;
  logic [31:0] i_reg_wdata = '0, addr = '0, s = 32'h760A, i_req_addr, o_reg_rdata, o_vme_addr;
  logic [31:0] m [12];
  logic [1:0] flags = '0, o_img_sel, o_vme_width;
  logic [2:0] o_vme_space;
  logic i_req_valid, i_req_io, i_req_write, o_claim, o_program, o_supervisor, o_blt, o_mblt, o_posted, o_write;
  int err_count = 0, tests_run = 0;
  always #12.5 i_clk = ~i_clk;
  pvwd_top i_pvwd_top (.*);
  pvwd_pci_master i_pvwd_pci_master (.i_clk(i_clk), .i_go(go), .i_addr(addr), .i_flags(flags),
    .o_req_valid(i_req_valid), .o_req_addr(i_req_addr), .o_req_io(i_req_io), .o_req_write(i_req_write));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : rnd
  function automatic logic [11:0] ofs(int k);
    return PVWD_IMG5_CTL_OFS + 12'(20 * (k / 4) + 4 * (k % 4));
  endfunction : ofs
  function automatic logic hit(int i, logic [31:0] a, logic io_c);
    return m[4*i][PVWD_EN_BIT] && m[4*i][PVWD_LAS_BIT] == io_c && a[31:16] >= m[4*i+1][31:16]
      && (m[4*i+2] == 32'h0 || a[31:16] < m[4*i+2][31:16]);
  endfunction : hit
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wreg(input int k, input logic [31:0] d);
    @(posedge i_clk);
    i_reg_addr <= ofs(k);
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
    if (k < 12) m[k] = d & (k % 4 == 0 ? PVWD_CTL_MASK : PVWD_WIN_MASK);
  endtask : wreg
  task automatic rchk(input int k);
    @(posedge i_clk);
    i_reg_addr <= ofs(k);
    i_reg_rd <= 1'b1;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    #1;
    chk("register", k < 12 ? m[k] : 32'h0, o_reg_rdata);
  endtask : rchk
  task automatic req(input logic [31:0] a, input logic [31:0] f);
    int sel;
    logic [31:0] c;
    logic [2:0] sp;
    logic [1:0] dw;
    logic hv, blk;
    sel = hit(0, a, f[0]) ? 0 : hit(1, a, f[0]) ? 1 : hit(2, a, f[0]) ? 2 : 3;
    hv = sel < 3;
    c = hv ? m[4*sel] : PVWD_CTL_RST;
    sp = c[PVWD_VAS_LSB+:3];
    dw = c[PVWD_VDW_LSB+:2];
    blk = sp == 3'h1 || sp == 3'h2;
    @(posedge i_clk);
    go <= 1'b1;
    addr <= a;
    flags <= f[1:0];
    @(posedge i_clk);
    go <= 1'b0;
    @(posedge i_clk);
    #1;
    chk("claim", hv, o_claim);
    if (hv) chk("select", sel, o_img_sel);
    if (hv) chk("vme address", {a[31:16] + m[4*sel+3][31:16], a[15:0]}, o_vme_addr);
    chk("attributes", {dw, sp, c[PVWD_PGM_BIT], c[PVWD_SUP_BIT], c[PVWD_VCT_BIT] && blk && dw != 2'h3,
      blk && dw == 2'h3, hv && f[1] && c[PVWD_PW_BIT] && !c[PVWD_LAS_BIT], hv && f[1]}, {o_vme_width,
      o_vme_space, o_program, o_supervisor, o_blt, o_mblt, o_posted, o_write});
  endtask : req
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge i_clk);
    err_count++;
    finish_test();
  end
  initial begin
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
    for (int k = 0; k < 12; k++) m[k] = k % 4 ? 32'h0 : PVWD_CTL_RST;
    for (int k = 0; k < 14; k++) rchk(k);
    for (int k = 12; k < 14; k++) wreg(k, rnd());
    for (int k = 12; k < 14; k++) rchk(k);
    $display("test reset done");
    wreg(5, 32'h12340000);
    wreg(6, 32'h12350000);
    wreg(7, 32'hFFFF0000);
    wreg(4, 32'h80000000);
    req(32'h1233FFFF, 32'h0);
    req(32'h12340000, 32'h2);
    req(32'h1234FFFF, 32'h2);
    req(32'h12350000, 32'h0);
    wreg(6, 32'h0);
    req(32'hFFFF1234, 32'h0);
    req(32'h12345678, 32'h3);
    wreg(0, 32'h80000000);
    req(32'h12345678, 32'h2);
    $display("test corners done");
    repeat (40) begin
      for (int k = 0; k < 12; k++) wreg(k, k % 4 == 0 || k % 4 == 3 ? rnd() : rnd() & 32'h000FFFFF);
      for (int k = 0; k < 12; k++) rchk(k);
      repeat (12) req(rnd() & 32'h000FFFFF, rnd());
    end
    $display("test random done");
    finish_test();
  end
endmodule : testbench
